// ===== sim/aior_far_model.sv
// Far side of the connector: line E with its pull-up or radio pulses, and the converter.
// Assumes the bench sets levels and codes; radio frames repeat every 200 cycles.
`timescale 1ns/10ps
module aior_far_model (
  input  wire logic            i_clk,
  input  wire logic            i_rc,
  input  wire logic            i_lvl_e,
  input  wire logic [7:0]      i_width,
  input  wire logic [3:0][7:0] i_code,
  output logic                 o_pin_e,
  output aior_pkg::aior_adc_t  o_adc
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge i_clk)
    cnt_q <= (cnt_q == 8'hc7) ? 8'h00 : cnt_q + 8'h01;
  assign o_pin_e = i_rc ? (cnt_q < i_width) : i_lvl_e;
  // One sample every fourth cycle, so quiet gaps exist between conversions.
  assign o_adc = '{valid: cnt_q[1:0] == 2'h3, chan: cnt_q[3:2], code: i_code[cnt_q[3:2]]};
endmodule // aior_far_model

// ===== sim/aior_properties.sv
// Concurrent checks on the ports of the accessory I/O block, attached by bind.
// Assumes one clock and a master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module aior_properties (
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire aior_pkg::aior_avs_req_t i_avs,
  input wire aior_pkg::aior_avs_rsp_t o_avs,
  input wire logic                    i_pin_stop,
  input wire aior_pkg::aior_adc_t     i_adc,
  input wire logic                    o_acc_on,
  input wire logic                    o_estop,
  input wire logic                    o_invert,
  input wire aior_pkg::aior_fb_t      o_fb
);
  logic [3:0][7:0] ana_q;
  logic [1:0]      op_q;
  logic [1:0]      stop_q;
  logic [1:0]      loop_q;
  logic            wr_q;
  logic            done;
  logic            rdone;
  logic            quiet;
  logic [7:0]      f1;
  assign done  = i_avs.write && !o_avs.waitrequest && i_avs.byteenable[0];
  assign rdone = i_avs.read && !o_avs.waitrequest;
  assign quiet = !i_adc.valid && !i_avs.write;
  assign f1    = (op_q == 2'h2) ? ana_q[2] : ana_q[0];
  // Shadow copies let the routing checks see the mode without peeking inside.
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      ana_q <= '0;
      {wr_q, loop_q, stop_q, op_q} <= 7'h00;
    end
    else
    begin
      if (i_adc.valid)
        ana_q[i_adc.chan] <= i_adc.code;
      if (done)
        wr_q <= 1'b1;
      if (done && i_avs.address == aior_pkg::OFF_CTRL)
        {loop_q, stop_q, op_q} <= i_avs.writedata[5:0];
    end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_bus_answer: assert property ((i_avs.read || i_avs.write) && o_avs.waitrequest
    |=> !o_avs.waitrequest ##1 o_avs.waitrequest) else $error("bus answer late or long");
  a_field_code: assert property (
    rdone && i_avs.address == aior_pkg::OFF_INPUTS |-> (o_avs.readdata & 32'hfffefefe) == 0)
    else $error("status field not 00 or 01");
  a_stop_noact: assert property (!wr_q |-> !o_estop && !o_invert)
    else $error("stop input acted before configuration");
  a_acc_apply: assert property (
    done && i_avs.address == aior_pkg::OFF_ACC && op_q != 2'h1
    |=> ##1 o_acc_on == $past(i_avs.writedata[0], 2))
    else $error("accessory command not applied");
  a_ana_read: assert property (
    rdone && i_avs.address == aior_pkg::OFF_ANA12 |-> o_avs.readdata[15:0] == ana_q[1:0])
    else $error("analog pair read wrong");
  a_pos_route: assert property (
    quiet [*3] ##0 loop_q == 2'h2 |-> o_fb.valid && o_fb.fb1 == f1
    && o_fb.cmd1 == ((op_q == 2'h2) ? ana_q[0] : 8'h00)) else $error("position routing wrong");
  a_spd_route: assert property (
    quiet [*3] ##0 loop_q == 2'h1 |-> o_fb.speed && o_fb.fb1 == (f1 ^ 8'h80))
    else $error("speed routing wrong");
  a_stop_idle: assert property (i_pin_stop [*8] |-> !o_estop && !o_invert)
    else $error("stop action while input open");
  a_invert_act: assert property (
    (stop_q == 2'h2 && !i_pin_stop) [*8] |-> o_invert && !o_estop)
    else $error("invert not raised");
  c_acc_write: cover property (done && i_avs.address == aior_pkg::OFF_ACC);
  c_invert: cover property ($rose(o_invert));
  c_radio_acc: cover property ($rose(o_acc_on) && op_q == 2'h1);
endmodule // aior_properties

bind aior_top aior_properties i_aior_properties (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_avs(i_avs), .o_avs(o_avs), .i_pin_stop(i_pin_stop), .i_adc(i_adc),
  .o_acc_on(o_acc_on), .o_estop(o_estop), .o_invert(o_invert), .o_fb(o_fb));

// ===== sim/aior_top_tb.sv
// Self-checking bench for the accessory I/O block with the far-side model.
// Assumes the checker is bound to aior_top and a radio threshold shortened to 20 cycles.
`timescale 1ns/10ps
module aior_top_tb;
  localparam int unsigned THR = 20;
  logic                    clk = 1'b0;
  logic                    rst_b = 1'b0;
  aior_pkg::aior_avs_req_t avs = '0;
  aior_pkg::aior_avs_rsp_t rsp;
  logic                    pin_f = 1'b1;
  logic                    pin_stop = 1'b1;
  logic                    enc = 1'b0;
  logic                    lvl_e = 1'b1;
  logic                    rc = 1'b0;
  logic [7:0]              width = 8'h00;
  logic [3:0][7:0]         code = '0;
  logic                    pin_e, acc_on, estop, invert;
  aior_pkg::aior_adc_t     adc;
  aior_pkg::aior_fb_t      fb;
  logic [31:0]             q;
  logic [1:0]              r;
  int                      n_errors = 0;
  int                      checks = 0;
  always #12.5 clk = ~clk;
  aior_top #(.P_RC_ON_CYC(THR)) i_aior_top (.i_clk(clk), .i_rst_b(rst_b), .i_avs(avs),
    .o_avs(rsp), .i_pin_e(pin_e), .i_pin_f(pin_f), .i_pin_stop(pin_stop),
    .i_encoder_present(enc), .i_adc(adc), .o_acc_on(acc_on), .o_estop(estop),
    .o_invert(invert), .o_fb(fb));
  aior_far_model i_aior_far_model (.i_clk(clk), .i_rc(rc), .i_lvl_e(lvl_e),
    .i_width(width), .i_code(code), .o_pin_e(pin_e), .o_adc(adc));
  task automatic conclude();
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
    do
    begin
      @(posedge clk);
    end
    while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    r = rsp.response;
    avs <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    compare("readdata", e, q);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    compare("response", aior_pkg::RESP_OKAY, r);
  endtask
  function automatic logic [31:0] inw(input logic e, input logic f, input logic s);
    return {8'h00, 7'h00, s, 7'h00, f, 7'h00, e};
  endfunction
  function automatic logic [31:0] fbx(input logic [1:0] op, input logic [1:0] lp);
    logic [7:0] x;
    logic       an;
    x = (lp == 2'h1) ? 8'h80 : 8'h00;
    an = (op == 2'h2);
    return {(an ? code[3] : code[1]) ^ x, (an ? code[2] : code[0]) ^ x,
      an ? code[1] : 8'h00, an ? code[0] : 8'h00};
  endfunction
  initial
  begin
    #(25 * 80000);
    n_errors++;
    conclude();
  end
  initial
  begin
    logic e, f, s, en;
    logic [1:0] op, lp;
    void'($urandom(23046));
    wt(16);
    rst_b <= 1'b1;
    wt(4);
    rd(aior_pkg::OFF_INPUTS, 32'h0001_0101);
    pin_stop <= 1'b0;
    wt(8);
    compare("stop outputs", 32'h0, {estop, invert});
    for (int i = 0; i < 6; i++)
    begin
      {e, f, s, en} = 4'($urandom);
      {lvl_e, pin_f, pin_stop, enc} <= {e, f, s, en};
      wt(8);
      rd(aior_pkg::OFF_INPUTS, inw(e & !en, f, s));
    end
    for (logic [1:0] m = 2'h1; m < 2'h3; m++)
    begin
      wr(aior_pkg::OFF_CTRL, {28'h0, m, 2'h0});
      pin_stop <= 1'b0;
      wt(8);
      compare("stop outputs", {m == 2'h1, m == 2'h2}, {estop, invert});
      pin_stop <= 1'b1;
      wt(8);
      compare("stop outputs", 32'h0, {estop, invert});
    end
    wr(aior_pkg::OFF_CTRL, 32'h0);
    for (int b = 1; b >= 0; b--)
    begin
      wr(aior_pkg::OFF_ACC, 32'(b));
      wt(2);
      compare("accessory", 32'(b), acc_on);
      rd(aior_pkg::OFF_ACC, 32'(b));
    end
    bus(1'b0, 5'h02, 32'h0);
    compare("response", aior_pkg::RESP_SLVERR, r);
    compare("readdata", 32'h0, q);
    code <= {8'hff, 8'h00, 8'($urandom), 8'h80};
    wt(40);
    rd(aior_pkg::OFF_ANA12, {16'h0, code[1], code[0]});
    rd(aior_pkg::OFF_ANA34, {16'h0, code[3], code[2]});
    for (int k = 0; k < 4; k++)
    begin
      op = k[1] ? 2'h2 : 2'h0;
      lp = k[0] ? 2'h2 : 2'h1;
      wr(aior_pkg::OFF_CTRL, {26'h0, lp, 2'h0, op});
      wt(4);
      rd(aior_pkg::OFF_FB, fbx(op, lp));
    end
    enc <= 1'b0;
    pin_stop <= 1'b1;
    for (logic [7:0] v = 8'h19; v < 8'h1b; v++)
    begin
      code[3] <= v;
      wr(aior_pkg::OFF_CTRL, 32'h0000_0040);
      wt(40);
      rd(aior_pkg::OFF_INPUTS, inw(v > 8'h19, pin_f, 1'b1));
    end
    wr(aior_pkg::OFF_CTRL, 32'h0000_0001);
    rc <= 1'b1;
    width <= 8'h28;
    wt(600);
    compare("accessory", 32'h1, acc_on);
    wr(aior_pkg::OFF_ACC, 32'h0);
    wt(2);
    compare("accessory", 32'h1, acc_on);
    rd(aior_pkg::OFF_INPUTS, 32'h0001_0000);
    width <= 8'h0a;
    wt(600);
    compare("accessory", 32'h0, acc_on);
    conclude();
  end
endmodule // aior_top_tb

// ===== src/aior_pkg.sv
// Constants, register map, encodings and carrier types for the accessory I/O block.
// Assumes a 40 MHz system clock and a converter that delivers 8-bit codes on that clock.
package aior_pkg;

  // Clock and timing.
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned RC_ON_US    = 1500;
  localparam int unsigned RC_ON_CYC   = RC_ON_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WIDTH_W     = 20;

  // Analog scaling.
  localparam int unsigned ADC_FS_MV   = 5000;
  localparam int unsigned ADC_MAX     = 255;
  localparam int unsigned E_THR_MV    = 500;
  localparam logic [7:0]  E_THR_CODE  = 8'(E_THR_MV * ADC_MAX / ADC_FS_MV);
  localparam logic [7:0]  SPD_ZERO    = 8'h80;

  // Status field codes.
  localparam logic [7:0]  FIELD_OFF   = 8'h00;
  localparam logic [7:0]  FIELD_ON    = 8'h01;

  // Register byte offsets.
  localparam int unsigned ADDR_W      = 5;
  localparam logic [4:0]  OFF_CTRL    = 5'h00;
  localparam logic [4:0]  OFF_ACC     = 5'h04;
  localparam logic [4:0]  OFF_INPUTS  = 5'h08;
  localparam logic [4:0]  OFF_ANA12   = 5'h0c;
  localparam logic [4:0]  OFF_ANA34   = 5'h10;
  localparam logic [4:0]  OFF_FB      = 5'h14;
  localparam logic [4:0]  OFF_RC2     = 5'h18;
  localparam logic [4:0]  OFF_RC3     = 5'h1c;

  // Control register fields.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STOP_LSB = 2;
  localparam int unsigned CTRL_LOOP_LSB = 4;
  localparam int unsigned CTRL_ESRC_BIT = 6;
  localparam int unsigned ACC_ON_BIT    = 0;

  // Avalon responses.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Synchronised pin indices.
  localparam int unsigned PIN_E       = 0;
  localparam int unsigned PIN_F       = 1;
  localparam int unsigned PIN_STOP    = 2;
  localparam int unsigned PIN_ENC     = 3;
  localparam int unsigned NPIN        = 4;
  localparam logic [3:0]  PIN_RST     = 4'h7;

  typedef enum logic [1:0] {OP_SERIAL = 2'h0, OP_RC = 2'h1, OP_ANALOG = 2'h2} aior_op_t;
  typedef enum logic [1:0] {STOP_NONE = 2'h0, STOP_ESTOP = 2'h1, STOP_INVERT = 2'h2} aior_stop_t;
  typedef enum logic [1:0] {LOOP_OPEN = 2'h0, LOOP_SPEED = 2'h1, LOOP_POS = 2'h2} aior_loop_t;
  typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} aior_bus_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } aior_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } aior_avs_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [7:0] code;
  } aior_adc_t;

  typedef struct packed {
    logic       valid;
    logic       speed;
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic [7:0] fb1;
    logic [7:0] fb2;
  } aior_fb_t;

  typedef struct packed {
    aior_bus_t                 bus;
    aior_avs_rsp_t             rsp;
    logic [1:0]                op;
    logic [1:0]                stop;
    logic [1:0]                loop;
    logic                      esrc;
    logic                      acc_cmd;
    logic                      acc_on;
    logic [3:0]                s1;
    logic [3:0]                s2;
    logic [3:0]                s3;
    logic [3:0]                pin;
    logic [1:0]                prev;
    logic [1:0][WIDTH_W-1:0]   cnt;
    logic [1:0][WIDTH_W-1:0]   width;
    logic [3:0][7:0]           ana;
    logic                      estop;
    logic                      invert;
    aior_fb_t                  fb;
  } aior_state_t;

  localparam aior_state_t STATE_RST = '{
    bus:     BUS_IDLE,
    rsp:     '{readdata: 32'h0000_0000, waitrequest: 1'b1, response: 2'h0},
    s1:      PIN_RST,
    s2:      PIN_RST,
    s3:      PIN_RST,
    pin:     PIN_RST,
    prev:    2'h0,
    fb:      '0,
    default: '0
  };

endpackage

// ===== src/aior_top.sv
// Accessory output, digital input status and analog input routing of a motor controller.
// Assumes an Avalon-MM master on i_clk, raw pins from the connector and a converter on i_clk.
//
// How it works
// - In radio mode channel 3 pulse width switches the accessory output.
// - In serial mode software writes accessory on or off and it is applied.
// - Input E reported only without encoder and in serial or analog mode.
// - In radio mode the input E line is measured as channel 3 pulses.
// - Input E reads on when open, thanks to the pull-up; low reads off.
// - Input status holds three byte fields, the first being input E.
// - Every status field is either 00 (off) or 01 (on).
// - Second status field holds input F.
// - Third status field holds the stop or invert input, always available.
// - Input E from analog 4 reads 1 above 0.5 V, else 0.
// - Input F digital in serial or analog mode, channel 2 pulses in radio mode.
// - After reset the stop or invert input triggers no action.
// - Configured for invert and active, the motor controls are inverted.
// - Configured for neither, the stop or invert input is a plain readable input.
// - Stop or invert input is active low; grounded triggers, open reads on.
// - Analog inputs 1-2 and 3-4 are readable in any mode.
// - Position feedback from inputs 1-2, or 3-4 in analog mode with commands on 1-2.
// - Speed feedback uses the same input assignment as position feedback.
// - Mid-scale speed feedback means zero speed.
// - Zero volts is full reverse, full scale is full forward.
// - Each analog input is kept as an 8-bit code, 0 to 255.
`timescale 1ns/10ps

module aior_top #(
  parameter int unsigned P_RC_ON_CYC = aior_pkg::RC_ON_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire aior_pkg::aior_avs_req_t i_avs,
  output      aior_pkg::aior_avs_rsp_t o_avs,
  input  wire logic                  i_pin_e,
  input  wire logic                  i_pin_f,
  input  wire logic                  i_pin_stop,
  input  wire logic                  i_encoder_present,
  input  wire aior_pkg::aior_adc_t   i_adc,
  output      logic                  o_acc_on,
  output      logic                  o_estop,
  output      logic                  o_invert,
  output      aior_pkg::aior_fb_t    o_fb
);

  // A status field only ever carries one of two codes, never the raw level.
  function automatic logic [7:0] field_code(input logic on);
    field_code = on ? aior_pkg::FIELD_ON : aior_pkg::FIELD_OFF;
  endfunction

  function automatic logic addr_hit(input logic [4:0] addr);
    addr_hit = (addr == aior_pkg::OFF_CTRL)   || (addr == aior_pkg::OFF_ACC)   ||
               (addr == aior_pkg::OFF_INPUTS) || (addr == aior_pkg::OFF_ANA12) ||
               (addr == aior_pkg::OFF_ANA34)  || (addr == aior_pkg::OFF_FB)    ||
               (addr == aior_pkg::OFF_RC2)    || (addr == aior_pkg::OFF_RC3);
  endfunction

  logic                  rst_meta_q;
  logic                  rst_b_q;
  aior_pkg::aior_state_t q;
  aior_pkg::aior_state_t d;

  logic                  is_rc;
  logic                  is_analog;
  logic                  e_level;
  logic                  e_ok;
  logic                  f_ok;
  logic                  stop_active;
  logic [1:0]            lines;
  logic [31:0]           rd_mux;
  logic [7:0]            fb_a;
  logic [7:0]            fb_b;

  // The release of reset is synchronised so that no flop leaves reset on a different edge.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_b_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_b_q    <= rst_meta_q;
    end
  end

  always_comb
  begin
    d = q;

    // Three-stage synchroniser; a change counts only once stages two and three agree.
    d.s1 = {i_encoder_present, i_pin_stop, i_pin_f, i_pin_e};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < aior_pkg::NPIN; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.pin[i] = q.s3[i];
      end
    end

    is_rc     = (q.op == aior_pkg::OP_RC);
    is_analog = (q.op == aior_pkg::OP_ANALOG);

    // Pulse width capture: index 0 is channel 2 on line F, index 1 is channel 3 on line E.
    lines  = {q.pin[aior_pkg::PIN_E], q.pin[aior_pkg::PIN_F]};
    d.prev = lines;
    for (int k = 0; k < 2; k++)
    begin
      if (!is_rc)
      begin
        d.cnt[k]   = '0;
        d.width[k] = '0;
      end
      else if (lines[k])
      begin
        // The counter saturates rather than wraps, so a stuck-high line stays a long pulse.
        if (q.cnt[k] != '1)
        begin
          d.cnt[k] = q.cnt[k] + 1'b1;
        end
      end
      else
      begin
        if (q.prev[k])
        begin
          d.width[k] = q.cnt[k];
        end
        d.cnt[k] = '0;
      end
    end

    if (i_adc.valid)
    begin
      d.ana[i_adc.chan] = i_adc.code;
    end

    // Input E may come from the shared analog 4 code instead of the digital comparator.
    e_level = q.esrc ? (q.ana[3] > aior_pkg::E_THR_CODE)
                     : q.pin[aior_pkg::PIN_E];
    e_ok    = !q.pin[aior_pkg::PIN_ENC] && !is_rc;
    f_ok    = !is_rc;

    if (is_rc)
    begin
      d.acc_on = (q.width[1] > aior_pkg::WIDTH_W'(P_RC_ON_CYC));
    end
    else
    begin
      d.acc_on = q.acc_cmd;
    end

    stop_active = !q.pin[aior_pkg::PIN_STOP];
    d.estop     = (q.stop == aior_pkg::STOP_ESTOP) && stop_active;
    d.invert    = (q.stop == aior_pkg::STOP_INVERT) && stop_active;

    // Speed feedback is re-centred so that code 0x80 is zero, 0 full reverse, 255 full forward.
    if (is_analog)
    begin
      fb_a = q.ana[2];
      fb_b = q.ana[3];
    end
    else
    begin
      fb_a = q.ana[0];
      fb_b = q.ana[1];
    end
    d.fb.valid = (q.loop != aior_pkg::LOOP_OPEN);
    d.fb.speed = (q.loop == aior_pkg::LOOP_SPEED);
    d.fb.cmd1  = is_analog ? q.ana[0] : 8'h00;
    d.fb.cmd2  = is_analog ? q.ana[1] : 8'h00;
    if (q.loop == aior_pkg::LOOP_SPEED)
    begin
      d.fb.fb1 = fb_a ^ aior_pkg::SPD_ZERO;
      d.fb.fb2 = fb_b ^ aior_pkg::SPD_ZERO;
    end
    else if (q.loop == aior_pkg::LOOP_POS)
    begin
      d.fb.fb1 = fb_a;
      d.fb.fb2 = fb_b;
    end
    else
    begin
      d.fb.fb1 = 8'h00;
      d.fb.fb2 = 8'h00;
    end

    rd_mux = 32'h0000_0000;
    case (i_avs.address)
      aior_pkg::OFF_CTRL:
        rd_mux = {25'h0, q.esrc, q.loop, q.stop, q.op};
      aior_pkg::OFF_ACC:
        rd_mux = {31'h0, q.acc_on};
      aior_pkg::OFF_INPUTS:
        rd_mux = {8'h00,
                  field_code(q.pin[aior_pkg::PIN_STOP]),
                  field_code(f_ok && q.pin[aior_pkg::PIN_F]),
                  field_code(e_ok && e_level)};
      aior_pkg::OFF_ANA12:
        rd_mux = {16'h0000, q.ana[1], q.ana[0]};
      aior_pkg::OFF_ANA34:
        rd_mux = {16'h0000, q.ana[3], q.ana[2]};
      aior_pkg::OFF_FB:
        rd_mux = {q.fb.fb2, q.fb.fb1, q.fb.cmd2, q.fb.cmd1};
      aior_pkg::OFF_RC2:
        rd_mux = 32'(q.width[0]);
      aior_pkg::OFF_RC3:
        rd_mux = 32'(q.width[1]);
      default:
        rd_mux = 32'h0000_0000;
    endcase

    // One wait cycle: read data is captured on acceptance, writes land on the completing edge.
    case (q.bus)
      aior_pkg::BUS_IDLE:
      begin
        if (i_avs.read || i_avs.write)
        begin
          d.bus             = aior_pkg::BUS_ACK;
          d.rsp.waitrequest = 1'b0;
          d.rsp.readdata    = i_avs.read ? rd_mux : 32'h0000_0000;
          d.rsp.response    = addr_hit(i_avs.address) ? aior_pkg::RESP_OKAY
                                                      : aior_pkg::RESP_SLVERR;
        end
      end
      aior_pkg::BUS_ACK:
      begin
        d.bus             = aior_pkg::BUS_IDLE;
        d.rsp.waitrequest = 1'b1;
        if (i_avs.write && i_avs.byteenable[0])
        begin
          if (i_avs.address == aior_pkg::OFF_CTRL)
          begin
            d.op   = i_avs.writedata[aior_pkg::CTRL_MODE_LSB +: 2];
            d.stop = i_avs.writedata[aior_pkg::CTRL_STOP_LSB +: 2];
            d.loop = i_avs.writedata[aior_pkg::CTRL_LOOP_LSB +: 2];
            d.esrc = i_avs.writedata[aior_pkg::CTRL_ESRC_BIT];
          end
          else if ((i_avs.address == aior_pkg::OFF_ACC) && !is_rc)
          begin
            d.acc_cmd = i_avs.writedata[aior_pkg::ACC_ON_BIT];
          end
        end
      end
      default:
      begin
        d.bus             = aior_pkg::BUS_IDLE;
        d.rsp.waitrequest = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_b_q)
  begin
    if (!rst_b_q)
    begin
      q <= aior_pkg::STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_avs    = q.rsp;
  assign o_acc_on = q.acc_on;
  assign o_estop  = q.estop;
  assign o_invert = q.invert;
  assign o_fb     = q.fb;

endmodule // aior_top
